// ==== verilog/nfh_host.sv ====
// Host controller driving an asynchronous multiplexed NAND target
`timescale 1ns/1ps
`include "nfh_defines.svh"
module nfh_host
  import nfh_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = `NFH_FIFO_DEPTH,
  parameter int SETUP_CYC = `NFH_T_SETUP_CYC,
  parameter int PULSE_CYC = `NFH_T_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic wide_mode,
  input wire logic req_valid,
  input wire nfh_op_t req_op,
  input wire logic [7:0] req_cmd,
  input wire logic [`NFH_COL_W-1:0] req_column,
  input wire logic [`NFH_PAGE_W-1:0] req_page,
  input wire logic [`NFH_BLOCK_W-1:0] req_block,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_target,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic rd_ready,
  input wire logic protect_req,
  input wire logic lock_strap_req,
  output logic target_busy,
  output logic plane_sel,
  output logic [1:0] target_sel_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  output logic lock_strap,
  output logic [DATA_W-1:0] io_out,
  output logic io_oe,
  input wire logic [DATA_W-1:0] io_in,
  input wire logic ready_busy_n
);
  localparam int CW = 8;

  // ==========================================================
  // Pin synchronisers: three stages on ready/busy, change taken on 2nd==3rd; two stages on the bus
  logic [2:0] rb_sync_q;
  logic rb_q, rb_d;
  logic [DATA_W-1:0] io_s1_q, io_s2_q;

  always_comb begin
    rb_d = (rb_sync_q[1] == rb_sync_q[2]) ? rb_sync_q[2] : rb_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rb_sync_q <= 3'h7;
      rb_q <= 1'b1;
      io_s1_q <= '0;
      io_s2_q <= '0;
    end else if (clk_en) begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_n};
      rb_q <= rb_d;
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  // ==========================================================
  // Read data FIFO; full FIFO stalls read cycles
  nfh_stream_if #(.WIDTH(DATA_W)) fin ();
  nfh_stream_if #(.WIDTH(DATA_W)) fout ();

  nfh_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr(fin),
    .rd(fout)
  );

  // ==========================================================
  // Address byte builder
  logic [2:0] acyc_q, acyc_d;
  logic [7:0] addr_byte;

  nfh_addr_pack u_pack (
    .wide_mode(wide_mode),
    .column_addr_bit(req_column),
    .page_addr_bit(req_page),
    .block_addr_bit(req_block),
    .cycle_idx(acyc_q),
    .addr_byte(addr_byte)
  );

  // ==========================================================
  // Bus cycle sequencer
  nfh_state_t st_q, st_d;
  nfh_op_t op_q, op_d;
  logic [CW-1:0] tmr_q, tmr_d;
  logic tgt_q, tgt_d;
  logic [DATA_W-1:0] wdat_q, wdat_d;
  logic [7:0] cmd_q, cmd_d;
  logic cap_q, cap_d;
  logic [DATA_W-1:0] cap_data_q, cap_data_d;
  logic accept;

  // Ready only when idle; FIFO room for a read gates accept, not req_ready
  function automatic logic can_take(input nfh_state_t s,
                                    input logic room);
    can_take = (s == NFH_IDLE) && room;
  endfunction

  // Byte or word on the bus, upper lines low for x8 use
  function automatic logic [DATA_W-1:0] lane(input logic [DATA_W-1:0] v,
                                             input logic wide);
    lane = wide ? v : {{(DATA_W-8){1'b0}}, v[7:0]};
  endfunction

  // A pending capture still owns a FIFO slot, so wait for its push
  assign accept = req_valid && !cap_q &&
                  can_take(st_q, fin.ready || (req_op != NFH_OP_READ));
  assign fin.valid = cap_q;
  assign fin.data = cap_data_q;
  assign fout.ready = rd_ready && !rd_valid;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    tmr_d = tmr_q;
    tgt_d = tgt_q;
    wdat_d = wdat_q;
    cmd_d = cmd_q;
    acyc_d = acyc_q;
    cap_d = 1'b0;
    cap_data_d = cap_data_q;
    unique case (st_q)
      NFH_IDLE: begin
        if (accept) begin
          op_d = req_op;
          tgt_d = req_target;
          cmd_d = req_cmd;
          wdat_d = lane(req_wdata, wide_mode);
          tmr_d = CW'(SETUP_CYC);
          st_d = NFH_SETUP;
        end
      end
      NFH_SETUP: begin
        // Latch lines settle before the strobe falls
        if (tmr_q <= 8'h01) begin
          tmr_d = CW'(PULSE_CYC);
          st_d = NFH_PULSE;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      NFH_PULSE: begin
        if (tmr_q <= 8'h01) begin
          tmr_d = CW'(SETUP_CYC);
          st_d = NFH_HOLD;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      NFH_HOLD: begin
        // Two-flop bus copy lags: it holds the next-to-last edge with strobe low
        if (op_q == NFH_OP_READ && tmr_q == CW'(SETUP_CYC)) begin
          cap_d = 1'b1;
          cap_data_d = lane(io_s2_q, wide_mode);
        end
        // Rising write strobe already happened; hold lines
        if (tmr_q <= 8'h01) begin
          st_d = NFH_IDLE;
          if (op_q == NFH_OP_ADDR) begin
            acyc_d = (acyc_q == `NFH_ADDR_CYCLES - 3'h1) ? 3'h0
                     : acyc_q + 3'h1;
          end else if (op_q == NFH_OP_CMD) begin
            acyc_d = 3'h0;
          end
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
    endcase
  end

  // ==========================================================
  // Pin values from next state so pins come from flip-flops
  logic [1:0] ce_n_d;
  logic cle_d, ale_d, we_n_d, re_n_d, oe_d;
  logic [DATA_W-1:0] io_d;
  logic busy_d, plane_d;
  logic rdv_d;
  logic [DATA_W-1:0] rdd_d;

  always_comb begin
    ce_n_d = 2'h3;
    cle_d = 1'b0;
    ale_d = 1'b0;
    we_n_d = 1'b1;
    re_n_d = 1'b1;
    oe_d = 1'b0;
    io_d = '0;
    if (st_d != NFH_IDLE) begin
      ce_n_d[tgt_d] = 1'b0;
      cle_d = (op_d == NFH_OP_CMD);
      ale_d = (op_d == NFH_OP_ADDR);
      if (op_d != NFH_OP_READ) begin
        // One shared bus for command, address and data
        oe_d = 1'b1;
        unique case (op_d)
          NFH_OP_CMD: io_d = lane({{(DATA_W-8){1'b0}}, cmd_d}, 1'b0);
          NFH_OP_ADDR: io_d = lane({{(DATA_W-8){1'b0}}, addr_byte}, 1'b0);
          default: io_d = wdat_d;
        endcase
        we_n_d = (st_d != NFH_PULSE);
      end else begin
        re_n_d = (st_d != NFH_PULSE);
      end
    end
    busy_d = !rb_q;
    plane_d = req_block[`NFH_PLANE_BIT - 6];
    rdv_d = rd_valid;
    rdd_d = rd_data;
    if (rd_valid && rd_ready) begin
      rdv_d = 1'b0;
    end
    if (fout.valid && fout.ready) begin
      rdv_d = 1'b1;
      rdd_d = fout.data;
    end
  end

  // ==========================================================
  // State and pin registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= NFH_IDLE;
      op_q <= NFH_OP_CMD;
      tmr_q <= '0;
      tgt_q <= 1'b0;
      wdat_q <= '0;
      cmd_q <= 8'h00;
      acyc_q <= 3'h0;
      cap_q <= 1'b0;
      cap_data_q <= '0;
      target_sel_n <= 2'h3;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= '0;
      io_oe <= 1'b0;
      req_ready <= 1'b0;
      // Held low through reset: no stray program or erase
      write_protect_n <= 1'b0;
      lock_strap <= 1'b0;
      target_busy <= 1'b0;
      plane_sel <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      op_q <= op_d;
      tmr_q <= tmr_d;
      tgt_q <= tgt_d;
      wdat_q <= wdat_d;
      cmd_q <= cmd_d;
      acyc_q <= acyc_d;
      cap_q <= cap_d;
      cap_data_q <= cap_data_d;
      target_sel_n <= ce_n_d;
      cmd_latch <= cle_d;
      addr_latch <= ale_d;
      write_strobe_n <= we_n_d;
      read_strobe_n <= re_n_d;
      io_out <= io_d;
      io_oe <= oe_d;
      req_ready <= can_take(st_d, 1'b1) && !accept;
      write_protect_n <= !protect_req;
      lock_strap <= lock_strap_req;
      target_busy <= busy_d;
      plane_sel <= plane_d;
      rd_valid <= rdv_d;
      rd_data <= rdd_d;
    end
  end
endmodule

// ==== verilog/nfh_defines.svh ====
// Timing counts, field positions and constants for the NAND host port
`ifndef NFH_DEFINES_SVH
`define NFH_DEFINES_SVH
`define NFH_CLK_NS 10
`define NFH_T_SETUP_NS 20
`define NFH_T_SETUP_CYC ((`NFH_T_SETUP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_PULSE_NS 20
`define NFH_T_PULSE_CYC ((`NFH_T_PULSE_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_ADDR_CYCLES 3'h5
`define NFH_COL_LO_MSB 7
`define NFH_PAGE_W 6
`define NFH_BLOCK_W 17
`define NFH_COL_W 12
`define NFH_PLANE_BIT 6
`define NFH_FIFO_DEPTH 8
`endif

// ==== verilog/nfh_pkg.sv ====
// Types shared by the NAND host port modules
package nfh_pkg;
  // Kind of bus cycle requested by the user side
  typedef enum logic [1:0] {
    NFH_OP_CMD = 2'h0,
    NFH_OP_ADDR = 2'h1,
    NFH_OP_WRITE = 2'h2,
    NFH_OP_READ = 2'h3
  } nfh_op_t;
  // Bus sequencer states, Gray along idle-setup-pulse-hold
  typedef enum logic [1:0] {
    NFH_IDLE = 2'b00,
    NFH_SETUP = 2'b01,
    NFH_PULSE = 2'b11,
    NFH_HOLD = 2'b10
  } nfh_state_t;
endpackage

// ==== verilog/nfh_stream_if.sv ====
// Valid/ready stream carrier between the host port modules
`timescale 1ns/1ps
interface nfh_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ==== verilog/nfh_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nfh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  nfh_stream_if.dst wr,
  nfh_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Advance with wrap, used by both pointers
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rp_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Next pointer and count values
  always_comb begin
    wp_d = push ? bump(wp_q) : wp_q;
    rp_d = pop ? bump(rp_q) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Registers only; data array has no reset on purpose
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem_q[wp_q] <= wr.data;
    end
  end
endmodule

// ==== verilog/nfh_addr_pack.sv ====
// Packs column, page and block into the five address bytes
`timescale 1ns/1ps
`include "nfh_defines.svh"
module nfh_addr_pack
  import nfh_pkg::*;
(
  input wire logic wide_mode,
  input wire logic [`NFH_COL_W-1:0] column_addr_bit,
  input wire logic [`NFH_PAGE_W-1:0] page_addr_bit,
  input wire logic [`NFH_BLOCK_W-1:0] block_addr_bit,
  input wire logic [2:0] cycle_idx,
  output logic [7:0] addr_byte
);
  logic [11:0] col;
  // ==========================================================
  // Column legalised: wide option has an 11-bit column
  always_comb begin
    col = column_addr_bit;
    if (!wide_mode) begin
      if (col[11]) begin
        col[10:6] = 5'h00;
      end
    end else begin
      col[11] = 1'b0;
      if (col[10]) begin
        col[9:5] = 5'h00;
      end
    end
  end

  // Byte per cycle; bits outside the space driven low
  always_comb begin
    unique case (cycle_idx)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {4'h0, col[11:8]};
      3'h2: addr_byte = {block_addr_bit[1:0], page_addr_bit};
      3'h3: addr_byte = block_addr_bit[9:2];
      3'h4: addr_byte = {7'h00, block_addr_bit[10]};
      default: addr_byte = 8'h00;
    endcase
  end
endmodule

// ==== tb/nfh_host_properties.sv ====
// Concurrent checks on the NAND host port pins
`timescale 1ns/1ps
module nfh_host_properties #(
  parameter int DATA_W = 16,
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wide_mode,
  input wire logic protect_req,
  input wire logic ready_busy_n,
  input wire logic target_busy,
  input wire logic [1:0] target_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [DATA_W-1:0] io_out,
  input wire logic io_oe
);
  // ==========
  // Bus cycle shape, busy sync and protect pin, single clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_latch_excl; !(cmd_latch && addr_latch); endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches");
  property p_one_target; (!write_strobe_n || !read_strobe_n) |-> $onehot(~target_sel_n); endproperty
  a_one_target: assert property (p_one_target) else $error("select bad");
  property p_wr_pulse; $fell(write_strobe_n) |-> ##PULSE_CYC $rose(write_strobe_n); endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse");
  property p_rd_pulse; $fell(read_strobe_n) |-> ##PULSE_CYC $rose(read_strobe_n); endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse");
  property p_setup; ($fell(write_strobe_n) || $fell(read_strobe_n)) |-> $past(target_sel_n, SETUP_CYC) != 2'b11; endproperty
  a_setup: assert property (p_setup) else $error("select setup");
  property p_wr_hold; $rose(write_strobe_n) |-> io_oe && $stable(io_out) && $stable({cmd_latch, addr_latch}); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write hold");
  property p_rd_bus; !read_strobe_n |-> !io_oe && !cmd_latch && !addr_latch && write_strobe_n; endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("read cycle");
  property p_hi_zero; wide_mode && (cmd_latch || addr_latch) |-> io_out[15:8] == 8'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper lines");
  property p_busy_on; $fell(ready_busy_n) |-> ##5 target_busy; endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy late");
  property p_busy_off; $rose(ready_busy_n) |-> ##5 !target_busy; endproperty
  a_busy_off: assert property (p_busy_off) else $error("ready late");
  property p_wp; $stable(protect_req) && !$past(reset) |-> write_protect_n == !protect_req; endproperty
  a_wp: assert property (p_wp) else $error("protect pin");
endmodule

// ==== tb/nfh_flash_model.sv ====
// Behavioural NAND target answering on target select zero
`timescale 1ns/1ps
module nfh_flash_model #(
  parameter logic [7:0] PROG_CMD = 8'h10,
  parameter int BUSY_NS = 300
) (
  input wire logic [1:0] target_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [15:0] io_out,
  output logic [15:0] io_dev,
  output logic rb_low
);
  // ==========
  // Captured traffic, read back by the bench
  logic [7:0] cmd_q[$];
  logic [15:0] addr_q[$];
  logic [15:0] data_q[$];
  logic [15:0] rd_word = 16'h3c01;
  logic plane = 1'b0;
  int prog_cnt = 0;
  initial begin
    io_dev = 16'h5aa5;
    rb_low = 1'b0;
  end
  // Latch on rising write strobe; one die sits behind select zero
  always @(posedge write_strobe_n) begin
    if (!target_sel_n[0] && read_strobe_n) begin
      if (cmd_latch && !addr_latch) begin
        cmd_q.push_back(io_out[7:0]);
        if (io_out[7:0] == PROG_CMD && write_protect_n) begin
          prog_cnt++;
          rb_low = 1'b1;
          rb_low <= #(BUSY_NS) 1'b0;
        end
      end else if (addr_latch && !cmd_latch) begin
        addr_q.push_back(io_out);
        if (addr_q.size() % 5 == 3) plane = io_out[6];
      end else if (!cmd_latch && !addr_latch) begin
        data_q.push_back(io_out);
      end
    end
  end
  // Drive next word on falling read strobe
  always @(negedge read_strobe_n) begin
    if (!target_sel_n[0] && !cmd_latch && !addr_latch) io_dev = rd_word;
  end
  // Released bus shows the inverse, so stale data never matches
  always @(posedge read_strobe_n) begin
    if (!target_sel_n[0]) rd_word = rd_word + 16'h0101;
    io_dev = ~io_dev;
  end
endmodule

// ==== tb/nfh_host_tb.sv ====
// Self-checking bench for the NAND host port
`timescale 1ns/1ps
`include "nfh_defines.svh"
module nfh_host_tb
  import nfh_pkg::*;
;
  // ==========
  // Stimulus and observed pins
  logic clk = 1'b0, reset = 1'b1, wide_mode = 1'b1, req_valid = 1'b0;
  nfh_op_t req_op = NFH_OP_CMD;
  logic [7:0] req_cmd = 8'h00;
  logic [`NFH_COL_W-1:0] req_column = 12'h000;
  logic [`NFH_PAGE_W-1:0] req_page = 6'h00;
  logic [`NFH_BLOCK_W-1:0] req_block = 17'h00000;
  logic [15:0] req_wdata = 16'h0000, rd_data, io_out, io_dev, io_in;
  logic req_target = 1'b0, rd_ready = 1'b0;
  logic protect_req = 1'b0, lock_strap_req = 1'b0;
  logic req_ready, rd_valid, target_busy, plane_sel, cmd_latch, addr_latch;
  logic write_strobe_n, read_strobe_n, write_protect_n, lock_strap;
  logic io_oe, rb_low, ready_busy_n;
  logic [1:0] target_sel_n;
  logic [31:0] seed = 32'h685920d7;
  int failures = 0, checked = 0;
  // Wire levels: host drives when enabled, pull-up on ready/busy
  assign io_in = io_oe ? io_out : io_dev;
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
  nfh_host i_dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .wide_mode(wide_mode), .req_valid(req_valid), .req_op(req_op),
    .req_cmd(req_cmd), .req_column(req_column), .req_page(req_page),
    .req_block(req_block), .req_wdata(req_wdata), .req_target(req_target),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .protect_req(protect_req),
    .lock_strap_req(lock_strap_req), .target_busy(target_busy),
    .plane_sel(plane_sel), .target_sel_n(target_sel_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_protect_n(write_protect_n), .lock_strap(lock_strap),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nfh_flash_model i_model (.target_sel_n(target_sel_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_protect_n(write_protect_n), .io_out(io_out), .io_dev(io_dev),
    .rb_low(rb_low));
  // ==========
  // Helpers
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected address byte; host must clear the forbidden column span
  function automatic logic [15:0] exp_addr(input logic w, input int i);
    logic [11:0] m;
    m = req_column;
    if (!w && m[11]) m[10:6] = 5'h00;
    if (w) m[11] = 1'b0;
    if (w && m[10]) m[9:5] = 5'h00;
    case (i)
      0: return {8'h00, m[7:0]};
      1: return {12'h000, m[11:8]};
      2: return {8'h00, req_block[1:0], req_page};
      3: return {8'h00, req_block[9:2]};
      default: return {15'h0000, req_block[10]};
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; took is high once the bus cycle has started
  task automatic op(input nfh_op_t k, output logic took);
    took = 1'b0;
    req_op <= k;
    req_valid <= 1'b1;
    for (int n = 0; n < 12 && !took; n++) begin
      @(posedge clk);
      took = (target_sel_n != 2'b11);
    end
    req_valid <= 1'b0;
    for (int n = 0; n < 20 && !req_ready; n++) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========
  // Watchdog, far beyond the expected run
  initial begin
    #500000;
    failures++;
    finish_test();
  end
  // ==========
  // Main sequence
  initial begin
    logic t;
    logic [15:0] m;
    int n_acc;
    repeat (3) @(posedge clk);
    check({target_sel_n, write_strobe_n, read_strobe_n, io_oe,
      write_protect_n, lock_strap}, 7'b1111000);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    // Address, command and data cycles, both bus widths
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wide_mode <= k[0];
      req_column <= (k < 2) ? 12'hfff : (k < 4) ? 12'h7ff : seed[11:0];
      req_page <= seed[17:12];
      req_block <= seed[31:15];
      req_cmd <= {1'b1, seed[6:0]};
      req_wdata <= seed[15:0];
      m = k[0] ? 16'hffff : 16'h00ff;
      op(NFH_OP_CMD, t);
      check(i_model.cmd_q[$], {1'b1, seed[6:0]});
      i_model.addr_q.delete();
      for (int i = 0; i < 5; i++) op(NFH_OP_ADDR, t);
      for (int i = 0; i < 5; i++) begin
        check(i_model.addr_q[i] & m, exp_addr(k[0], i));
      end
      check({plane_sel, i_model.plane}, {2{req_block[0]}});
      op(NFH_OP_WRITE, t);
      check(i_model.data_q[$] & m, seed[15:0] & m);
    end
    // Fill the read buffer until it refuses, then drain it
    wide_mode <= 1'b1;
    n_acc = 0;
    for (int k = 0; k < 12; k++) begin
      op(NFH_OP_READ, t);
      n_acc += t;
    end
    check(n_acc, `NFH_FIFO_DEPTH);
    rd_ready <= 1'b1;
    for (int k = 0; k < n_acc; k++) begin
      for (int n = 0; n < 20; n++) begin
        @(posedge clk);
        if (rd_valid) break;
      end
      check(rd_data, 16'h3c01 + 16'h0101 * k);
    end
    rd_ready <= 1'b0;
    // Other target: cycle runs but target zero stays deaf
    req_target <= 1'b1;
    n_acc = i_model.cmd_q.size();
    op(NFH_OP_CMD, t);
    check(t, 1'b1);
    check(i_model.cmd_q.size(), n_acc);
    // Protected program is blocked, then runs and shows busy
    req_target <= 1'b0;
    protect_req <= 1'b1;
    lock_strap_req <= 1'b1;
    req_cmd <= 8'h10;
    repeat (3) @(posedge clk);
    check({write_protect_n, lock_strap}, 2'b01);
    op(NFH_OP_CMD, t);
    check(i_model.prog_cnt, 0);
    protect_req <= 1'b0;
    repeat (3) @(posedge clk);
    op(NFH_OP_CMD, t);
    repeat (3) @(posedge clk);
    check(target_busy, 1'b1);
    check(i_model.prog_cnt, 1);
    repeat (40) @(posedge clk);
    check(target_busy, 1'b0);
    finish_test();
  end
endmodule
bind nfh_host nfh_host_properties #(.DATA_W(DATA_W),
  .SETUP_CYC(SETUP_CYC), .PULSE_CYC(PULSE_CYC)) i_props (.clk(clk),
  .reset(reset), .wide_mode(wide_mode), .protect_req(protect_req),
  .ready_busy_n(ready_busy_n), .target_busy(target_busy),
  .target_sel_n(target_sel_n), .cmd_latch(cmd_latch),
  .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
  .io_out(io_out), .io_oe(io_oe));
